// >>> src/fpu_hbh_pkg.sv
// constants, types and carriers shared by the coprocessor host bus handshake
// Overview of operation
// - reset abandons the running command, zeroes status and restarts byte pointers
// - after reset done, service request and fault outputs are low
// - cmd_not_data with read or write strobe selects push, pop, command or status
// - done rises at command end; falls on done ack low, any access, reset
// - with done ack held low, done is a pulse about one clock wide
// - a selected read clears done after the read strobe falls
// - service request rises at command end only if its enable bit was one
// - service request clears on service ack low or on reset
// - service request clears after finishing a command whose enable bit is zero
// - bus bit 0 is least significant, bit 7 most; high means one
// - operands pushed least significant byte first; results popped most significant first
// - fault rises on divide by zero, exponent overflow or underflow
// - fault clears on a selected status read after the read strobe falls, or reset
// - fault follows status error bits, which may rise before command completion
// - wait goes low while selected with both strobes high, anticipating an access
// - write starts on write strobe fall; wait rises to acknowledge it
// - read starts on read strobe fall; wait rises with data, driven while strobe low
// - with select tied low, wait stays low between accesses
// - command bit 7 enables service request; low seven bits select the operation
// - a selected write clears done after the write strobe rises
// - an access other than a status read during execution holds wait low until execution completes
package fpu_hbh_pkg;

    // widths of the host byte lane and internal fields
    localparam int BUS_W = 8;
    localparam int OP_W = 7;
    localparam int IDX_W = 3;
    localparam int ERR_W = 3;
    localparam int PIN_W = 14;

    // command byte layout
    localparam int SVC_EN_BIT = 7;

    // push buffer depth in words
    localparam int FIFO_DEPTH = 4;

    // reset and idle values
    localparam logic [ERR_W-1:0] ERR_CLEAR = 3'h0;
    localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
    localparam logic [IDX_W-1:0] IDX_STEP = 3'h1;
    localparam logic [BUS_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] ST_PAD = 4'h0;
    localparam logic [PIN_W-1:0] PIN_IDLE = 14'h3f00;

    // handshake sequencer states
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_WR_PEND = 5'h02,
        S_WR_END = 5'h04,
        S_RD_PEND = 5'h08,
        S_RD_END = 5'h10
    } hs_state_e;

    // host pins as sampled
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic cmd_not_data;
        logic done_ack_n;
        logic svc_ack_n;
        logic [BUS_W-1:0] bus;
    } pin_in_s;

    // command handed to the arithmetic core
    typedef struct packed {
        logic svc_en;
        logic [OP_W-1:0] op;
    } cmd_s;

    // operand byte with its position, 0 is least significant
    typedef struct packed {
        logic [IDX_W-1:0] idx;
        logic [BUS_W-1:0] data;
    } push_s;

endpackage

// >>> src/byte_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // honest flags straight from the occupancy count
    assign in_ready = count_ff != FULL_CNT;
    assign out_valid = count_ff != '0;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_ff];

    // storage has no reset; empty flag masks stale words
    always_ff @(posedge clk_sys)
    begin
        if (clk_en && push)
            mem[wr_ptr_ff] <= in_data;
    end

    // pointers wrap explicitly so any depth works
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end
        else if (clk_en)
        begin
            if (push)
                wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// >>> src/fpu_host_bus_handshake.sv
// host bus handshake of the floating-point coprocessor
`timescale 1ns/10ps
`default_nettype none
module fpu_host_bus_handshake (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic cmd_not_data,
    input wire logic [7:0] host_bus_in,
    output logic [7:0] host_bus_out,
    output logic host_bus_oe,
    output logic bus_wait_n,
    input wire logic done_ack_n,
    output logic done,
    input wire logic svc_ack_n,
    output logic svc_request,
    output logic fault,
    output logic core_clear,
    output var fpu_hbh_pkg::cmd_s cmd_word,
    output logic cmd_valid,
    input wire logic cmd_done,
    input wire logic [2:0] err_set,
    output var fpu_hbh_pkg::push_s push_word,
    output logic push_valid,
    input wire logic push_ready,
    input wire logic [7:0] pop_byte,
    input wire logic pop_valid,
    output logic pop_ready,
    output logic [2:0] pop_idx
);
    // ==================================================================
    // pin synchronisers
    fpu_hbh_pkg::pin_in_s pin_raw;
    fpu_hbh_pkg::pin_in_s meta_ff;
    fpu_hbh_pkg::pin_in_s pin_ff;
    logic rd_prev_ff;
    logic wr_prev_ff;

    assign pin_raw = fpu_hbh_pkg::pin_in_s'({cs_n, rd_n, wr_n, cmd_not_data, done_ack_n, svc_ack_n, host_bus_in});

    // two stages before any logic; idle value avoids false strobe edges
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_ff <= fpu_hbh_pkg::PIN_IDLE;
            pin_ff <= fpu_hbh_pkg::PIN_IDLE;
            rd_prev_ff <= 1'b1;
            wr_prev_ff <= 1'b1;
        end
        else if (clk_en)
        begin
            meta_ff <= pin_raw;
            pin_ff <= meta_ff;
            rd_prev_ff <= pin_ff.rd_n;
            wr_prev_ff <= pin_ff.wr_n;
        end
    end

    // ==================================================================
    // access decode
    fpu_hbh_pkg::hs_state_e state_ff;
    fpu_hbh_pkg::hs_state_e nxt_state;
    logic busy_ff;
    logic cs_on;
    logic is_cmd;
    logic anticip;
    logic rd_fall;
    logic wr_fall;
    logic wr_go;
    logic rd_go;
    logic wr_release;
    logic rd_release;
    logic acc_clr;
    logic cmd_issue;
    logic st_rd;
    logic done_ev;
    logic fifo_in_ready;
    logic fifo_in_valid;
    logic pop_take;
    logic [7:0] status_byte;

    // read strobe wins if both fall together: the undefined case is never a write
    assign cs_on = !pin_ff.cs_n;
    assign is_cmd = pin_ff.cmd_not_data;
    assign anticip = cs_on & pin_ff.rd_n & pin_ff.wr_n;
    assign rd_fall = cs_on & !pin_ff.rd_n & rd_prev_ff;
    assign wr_fall = cs_on & !pin_ff.wr_n & wr_prev_ff & pin_ff.rd_n;

    // data and command writes wait for the running command to finish
    assign wr_go = (state_ff == fpu_hbh_pkg::S_WR_PEND) & !busy_ff & (is_cmd | fifo_in_ready);
    assign pop_ready = (state_ff == fpu_hbh_pkg::S_RD_PEND) & !is_cmd & !busy_ff;
    assign pop_take = pop_ready & pop_valid;
    assign rd_go = (state_ff == fpu_hbh_pkg::S_RD_PEND) & (is_cmd | pop_take);
    assign wr_release = (state_ff == fpu_hbh_pkg::S_WR_END) & pin_ff.wr_n;
    assign rd_release = (state_ff == fpu_hbh_pkg::S_RD_END) & pin_ff.rd_n;

    // side effects of accesses
    assign acc_clr = ((state_ff == fpu_hbh_pkg::S_IDLE) & rd_fall) | wr_release;
    assign cmd_issue = wr_go & is_cmd;
    assign fifo_in_valid = wr_go & !is_cmd;
    assign st_rd = rd_go & is_cmd;
    assign done_ev = cmd_done & busy_ff;
    assign status_byte = {busy_ff, fpu_hbh_pkg::ST_PAD, fault_err()};
    assign host_bus_oe = state_ff == fpu_hbh_pkg::S_RD_END;

    // ==================================================================
    // handshake sequencer
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            fpu_hbh_pkg::S_IDLE:
                if (rd_fall)
                    nxt_state = fpu_hbh_pkg::S_RD_PEND;
                else if (wr_fall)
                    nxt_state = fpu_hbh_pkg::S_WR_PEND;
            fpu_hbh_pkg::S_WR_PEND:
                if (wr_go)
                    nxt_state = fpu_hbh_pkg::S_WR_END;
            fpu_hbh_pkg::S_WR_END:
                if (wr_release)
                    nxt_state = fpu_hbh_pkg::S_IDLE;
            fpu_hbh_pkg::S_RD_PEND:
                if (rd_go)
                    nxt_state = fpu_hbh_pkg::S_RD_END;
            fpu_hbh_pkg::S_RD_END:
                if (rd_release)
                    nxt_state = fpu_hbh_pkg::S_IDLE;
            default:
                nxt_state = fpu_hbh_pkg::S_IDLE;
        endcase
    end

    // wait is high in the end states, and in idle unless a select with both strobes high anticipates an access
    logic nxt_wait_n;
    assign nxt_wait_n = (nxt_state == fpu_hbh_pkg::S_WR_END) | (nxt_state == fpu_hbh_pkg::S_RD_END) |
                        ((nxt_state == fpu_hbh_pkg::S_IDLE) & !anticip);

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= fpu_hbh_pkg::S_IDLE;
            bus_wait_n <= 1'b1;
        end
        else if (clk_en)
        begin
            state_ff <= nxt_state;
            bus_wait_n <= nxt_wait_n;
        end
    end

    // ==================================================================
    // completion flags
    logic [fpu_hbh_pkg::ERR_W-1:0] err_ff;
    logic [fpu_hbh_pkg::ERR_W-1:0] nxt_err;
    logic svc_en_ff;
    logic nxt_done;
    logic nxt_svc;
    logic nxt_busy;

    function automatic logic [fpu_hbh_pkg::ERR_W-1:0] fault_err();
        return err_ff;
    endfunction

    // a completion in the clearing cycle wins, so tied-low acks give a one-clock pulse
    assign nxt_done = done_ev | (done & !acc_clr & pin_ff.done_ack_n);
    assign nxt_svc = done_ev ? svc_en_ff : (svc_request & pin_ff.svc_ack_n);
    assign nxt_err = (err_ff & {fpu_hbh_pkg::ERR_W{!st_rd}}) | err_set;
    assign nxt_busy = cmd_issue | (busy_ff & !cmd_done);

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            done <= 1'b0;
            svc_request <= 1'b0;
            fault <= 1'b0;
            err_ff <= fpu_hbh_pkg::ERR_CLEAR;
            busy_ff <= 1'b0;
            svc_en_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            done <= nxt_done;
            svc_request <= nxt_svc;
            err_ff <= nxt_err;
            fault <= |nxt_err;
            busy_ff <= nxt_busy;
            if (cmd_issue)
                svc_en_ff <= pin_ff.bus[fpu_hbh_pkg::SVC_EN_BIT];
        end
    end

    // ==================================================================
    // core side transfers
    logic [fpu_hbh_pkg::IDX_W-1:0] push_idx_ff;

    // restart pulse lets the core drop its command and stack pointer
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            core_clear <= 1'b1;
            cmd_valid <= 1'b0;
            cmd_word <= '0;
            host_bus_out <= fpu_hbh_pkg::BYTE_ZERO;
            push_idx_ff <= fpu_hbh_pkg::IDX_FIRST;
            pop_idx <= fpu_hbh_pkg::IDX_FIRST;
        end
        else if (clk_en)
        begin
            core_clear <= 1'b0;
            cmd_valid <= cmd_issue;
            if (cmd_issue)
                cmd_word <= fpu_hbh_pkg::cmd_s'(pin_ff.bus);
            if (rd_go)
                host_bus_out <= is_cmd ? status_byte : pop_byte;
            if (fifo_in_valid)
                push_idx_ff <= push_idx_ff + fpu_hbh_pkg::IDX_STEP;
            if (pop_take)
                pop_idx <= pop_idx + fpu_hbh_pkg::IDX_STEP;
        end
    end

    // buffer stalls the write acknowledge when the core falls behind
    byte_fifo #(
        .WIDTH($bits(fpu_hbh_pkg::push_s)),
        .DEPTH(fpu_hbh_pkg::FIFO_DEPTH)
    ) push_buf (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({push_idx_ff, pin_ff.bus}),
        .out_valid(push_valid),
        .out_ready(push_ready),
        .out_data(push_word)
    );

    // ==================================================================
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence wr_accept_q;
        clk_en && wr_go;
    endsequence

    sequence wr_ack_q;
        bus_wait_n && state_ff == fpu_hbh_pkg::S_WR_END;
    endsequence

    sequence rd_accept_q;
        clk_en && rd_go;
    endsequence

    sequence rd_drive_q;
        bus_wait_n && host_bus_oe;
    endsequence

    reset_quiet_a:
    assert property ($past(sys_rst) |-> !done && !svc_request && !fault)
        else $error("flags not low after reset");

    done_set_a:
    assert property (clk_en && done_ev |=> done)
        else $error("done missed completion");

    done_pulse_a:
    assert property (clk_en && done && !pin_ff.done_ack_n && !done_ev |=> !done)
        else $error("done outlived acknowledge");

    rd_done_clr_a:
    assert property (clk_en && acc_clr && !done_ev |=> !done)
        else $error("access did not clear done");

    svc_on_a:
    assert property (clk_en && done_ev && svc_en_ff |=> svc_request)
        else $error("service request not raised");

    svc_off_a:
    assert property (clk_en && done_ev && !svc_en_ff |=> !svc_request)
        else $error("service request not cleared");

    svc_ack_a:
    assert property (clk_en && !pin_ff.svc_ack_n && !done_ev |=> !svc_request)
        else $error("service ack ignored");

    fault_clr_a:
    assert property (clk_en && st_rd && err_set == fpu_hbh_pkg::ERR_CLEAR |=> !fault)
        else $error("status read left fault set");

    fault_set_a:
    assert property (clk_en && err_set != fpu_hbh_pkg::ERR_CLEAR |=> fault)
        else $error("error did not raise fault");

    wait_anticip_a:
    assert property (clk_en && state_ff == fpu_hbh_pkg::S_IDLE && anticip && !rd_fall |=> !bus_wait_n)
        else $error("wait not low while selected");

    wr_ack_a:
    assert property (wr_accept_q |=> wr_ack_q)
        else $error("write not acknowledged");

    rd_data_a:
    assert property (rd_accept_q |=> rd_drive_q ##0 host_bus_out == $past(is_cmd ? status_byte : pop_byte))
        else $error("read data not presented");

    busy_hold_a:
    assert property (clk_en && state_ff == fpu_hbh_pkg::S_WR_PEND && busy_ff && !cmd_done |=> !bus_wait_n)
        else $error("wait released during execution");
endmodule
`default_nettype wire

// >>> bench/host_model.sv
// bench model of the host processor that drives the coprocessor pins
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic clk_sys,
    input wire logic bus_wait_n,
    input wire logic [7:0] host_bus_out,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic cmd_not_data,
    output logic [7:0] host_bus_in,
    output logic got,
    output logic [7:0] got_data,
    output logic pre_wait,
    output logic post_wait,
    output logic timed_out
);
    logic drive_on;

    // ====================================================
    // idle pins
    initial
    begin
        {cs_n, rd_n, wr_n} = 3'h7;
        {cmd_not_data, got, got_data, pre_wait, post_wait, timed_out, drive_on} = '0;
        host_bus_in = 8'h5a;
    end

    // a released bus toggles every cycle, so a stale byte can never pass
    always @(posedge clk_sys)
    begin
        if (!drive_on)
            host_bus_in <= ~host_bus_in;
    end

    // ====================================================
    // one access: strobe held until wait is seen high
    task automatic access(input logic is_rd, input logic cnd, input logic [7:0] wdata);
        int n;
        @(negedge clk_sys);
        cs_n = 1'b0;
        cmd_not_data = cnd;
        drive_on = !is_rd;
        if (!is_rd)
            host_bus_in = wdata;
        repeat (4) @(negedge clk_sys);
        pre_wait = bus_wait_n;
        if (is_rd)
            rd_n = 1'b0;
        else
            wr_n = 1'b0;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (bus_wait_n !== 1'b1 && n < 3000);
        timed_out = timed_out | (n >= 3000);
        got_data = host_bus_out;
        {rd_n, wr_n} = 2'h3;
        got = is_rd;
        @(negedge clk_sys);
        got = 1'b0;
        repeat (3) @(negedge clk_sys);
        post_wait = bus_wait_n;
        cs_n = 1'b1;
        drive_on = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_fpu_host_bus_handshake.sv
// self-checking bench of the coprocessor host bus handshake
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("[FAIL] %0t %s", $time, msg); \
        end \
    end
module tb_fpu_host_bus_handshake;
    logic clk_sys, sys_rst, clk_en, cs_n, rd_n, wr_n, cmd_not_data, host_bus_oe, bus_wait_n;
    logic done_ack_n, done, svc_ack_n, svc_request, fault, core_clear, cmd_valid, cmd_done;
    logic push_valid, push_ready, pop_valid, pop_ready, got, pre_wait, post_wait, timed_out;
    logic core_busy, core_stall;
    logic [7:0] host_bus_in, host_bus_out, pop_byte, got_data;
    logic [2:0] err_set, pop_idx, push_ptr, err_code;
    logic [6:0] core_op;
    logic [31:0] result;
    fpu_hbh_pkg::cmd_s cmd_word;
    fpu_hbh_pkg::cmd_s exp_cmd[$];
    fpu_hbh_pkg::push_s push_word;
    fpu_hbh_pkg::push_s exp_push[$];
    logic [7:0] exp_rd[$];
    int core_cnt, exec_len, done_hi, num_errors, n_compared;

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    fpu_host_bus_handshake dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .cmd_not_data(cmd_not_data), .host_bus_in(host_bus_in),
        .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe), .bus_wait_n(bus_wait_n),
        .done_ack_n(done_ack_n), .done(done), .svc_ack_n(svc_ack_n), .svc_request(svc_request),
        .fault(fault), .core_clear(core_clear), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
        .cmd_done(cmd_done), .err_set(err_set), .push_word(push_word), .push_valid(push_valid),
        .push_ready(push_ready), .pop_byte(pop_byte), .pop_valid(pop_valid), .pop_ready(pop_ready),
        .pop_idx(pop_idx));

    host_model host (.clk_sys(clk_sys), .bus_wait_n(bus_wait_n), .host_bus_out(host_bus_out),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .cmd_not_data(cmd_not_data), .host_bus_in(host_bus_in),
        .got(got), .got_data(got_data), .pre_wait(pre_wait), .post_wait(post_wait),
        .timed_out(timed_out));

    // ====================================================
    // core stand-in: fixed run length, divide reports an error halfway
    always @(negedge clk_sys)
    begin
        cmd_done <= 1'b0;
        err_set <= 3'h0;
        push_ready <= !core_stall;
        pop_valid <= pop_ready;
        pop_byte <= result[8*(3-int'(pop_idx[1:0])) +: 8];
        if (core_clear)
            core_busy <= 1'b0;
        else if (cmd_valid)
        begin
            core_busy <= 1'b1;
            core_cnt <= exec_len;
            core_op <= cmd_word.op;
        end
        else if (core_busy)
        begin
            core_cnt <= core_cnt - 1;
            if (core_cnt == exec_len / 2 && core_op == 7'h04)
                err_set <= err_code;
            if (core_cnt == 1)
            begin
                cmd_done <= 1'b1;
                core_busy <= 1'b0;
            end
        end
    end

    // ====================================================
    // result watcher: each result takes the oldest note
    always @(posedge clk_sys)
    begin
        if (push_valid && push_ready)
            `CHK(push_word, exp_push.pop_front(), "push word")
        if (cmd_valid)
            `CHK(cmd_word, exp_cmd.pop_front(), "command word")
        if (got)
        begin
            `CHK(got_data, exp_rd.pop_front(), "read byte")
            `CHK(host_bus_oe, 1'b1, "bus driven on read")
        end
        if (done)
            done_hi <= done_hi + 1;
    end

    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic acc(input logic is_rd, input logic cnd, input logic [7:0] b);
        host.access(is_rd, cnd, b);
        `CHK(pre_wait, 1'b0, "wait low before strobe")
        `CHK(post_wait, 1'b0, "wait low between accesses")
    endtask

    task automatic push(input logic [7:0] b);
        exp_push.push_back({push_ptr, b});
        push_ptr++;
        acc(1'b0, 1'b0, b);
    endtask

    task automatic cmd(input logic svc, input logic [6:0] op);
        exp_cmd.push_back({svc, op});
        acc(1'b0, 1'b1, {svc, op});
    endtask

    task automatic rd(input logic cnd, input logic [7:0] e);
        exp_rd.push_back(e);
        acc(1'b1, cnd, 8'h00);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (core_busy !== 1'b0 && n < 5000)
        begin
            @(negedge clk_sys);
            n++;
        end
        cycles(4);
    endtask

    // reset held eight cycles, beyond the minimum of five
    task automatic do_reset;
        sys_rst = 1'b1;
        cycles(8);
        `CHK({done, svc_request, fault, core_clear}, 4'h1, "reset outputs")
        sys_rst = 1'b0;
        push_ptr = 3'h0;
        cycles(4);
    endtask

    task automatic note(input string s);
        $display("test %s ended, mismatches %0d", s, num_errors);
    endtask

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ====================================================
    // main sequence
    initial
    begin
        {sys_rst, done_ack_n, svc_ack_n, clk_en} = 4'hf;
        {cmd_done, push_ready, pop_valid, core_stall, core_busy} = '0;
        {err_set, err_code, pop_byte, push_ptr, core_op} = '0;
        {exec_len, done_hi, num_errors, n_compared, core_cnt} = {32'd20, 128'd0};
        void'($urandom(64420));
        result = $urandom;
        do_reset;
        note("reset");
        for (int i = 0; i < 4; i++) push(8'($urandom));
        cmd(1'b1, 7'h01);
        wait_idle;
        `CHK({done, svc_request}, 2'h3, "done with service request")
        for (int i = 3; i >= 0; i--)
        begin
            rd(1'b0, result[8*i +: 8]);
            `CHK(done, 1'b0, "read clears done")
        end
        svc_ack_n = 1'b0;
        cycles(4);
        `CHK(svc_request, 1'b0, "service ack clears")
        svc_ack_n = 1'b1;
        note("push command pop");
        cmd(1'b1, 7'h01);
        wait_idle;
        cmd(1'b0, 7'h02);
        `CHK(done, 1'b0, "write clears done")
        push(8'($urandom));
        `CHK(core_busy, 1'b0, "push held while busy")
        wait_idle;
        // the held push is released after completion, so its release clears done too
        `CHK({done, svc_request}, 2'h0, "service request dropped")
        note("service enable off");
        exec_len = 80;
        for (int k = 0; k < 3; k++)
        begin
            err_code = 3'h1 << k;
            cmd(1'b0, 7'h04);
            cycles(40);
            `CHK({fault, core_busy}, 2'h3, "fault before completion")
            rd(1'b1, {1'b1, 4'h0, err_code});
            `CHK(fault, 1'b0, "status read clears fault")
            wait_idle;
        end
        note("errors");
        exec_len = 20;
        core_stall = 1'b1;
        fork
            for (int i = 0; i < 7; i++) push(8'($urandom));
            begin
                cycles(100);
                `CHK({bus_wait_n, push_valid}, 2'h1, "full buffer holds write")
                core_stall = 1'b0;
            end
        join
        note("buffer full");
        done_ack_n = 1'b0;
        cmd(1'b0, 7'h01);
        done_hi = 0;
        wait_idle;
        `CHK(done_hi inside {[1:3]}, 1'b1, "done pulse width")
        done_ack_n = 1'b1;
        note("done pulse");
        cmd(1'b1, 7'h03);
        cycles(5);
        do_reset;
        `CHK({done, svc_request, fault, core_busy}, 4'h0, "abandoned command")
        cmd(1'b1, 7'h01);
        wait_idle;
        `CHK(done, 1'b1, "runs after reset")
        // a low enable must freeze the flag even with the acknowledge pending
        clk_en = 1'b0;
        done_ack_n = 1'b0;
        cycles(4);
        `CHK(done, 1'b1, "frozen while disabled")
        clk_en = 1'b1;
        cycles(4);
        `CHK(done, 1'b0, "done ack clears")
        done_ack_n = 1'b1;
        `CHK(timed_out, 1'b0, "host handshake hang")
        note("mid-run reset");
        conclude;
    end

    // watchdog at 40000 cycles, far beyond the fewer than a thousand cycles the tests need
    initial
    begin
        #200000;
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude;
    end
endmodule
`default_nettype wire
